// ===== qpm_pkg.sv
// package of register map, field layout, reset values and timing for the quad power monitor
package qpm_pkg;
    localparam int NUM_CH = 4;
    // printed offsets are word indexes (0x01 is not word aligned), byte address is four times
    localparam logic [7:0] IDX_SHUNT = 8'h00;
    localparam logic [7:0] IDX_BUS = 8'h01;
    localparam logic [7:0] IDX_CURR = 8'h02;
    localparam logic [7:0] IDX_POWER = 8'h03;
    localparam logic [7:0] IDX_ENERGY = 8'h04;
    localparam logic [7:0] CH_STRIDE = 8'h08;
    localparam logic [7:0] IDX_SETUP_A = 8'h20;
    localparam logic [7:0] IDX_SETUP_B = 8'h21;
    localparam logic [7:0] IDX_CAL_BASE = 8'h24;
    localparam logic [7:0] IDX_FCFG_BASE = 8'h28;
    localparam logic [7:0] IDX_THR_BASE = 8'h2c;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
    // setup register a: bit0 range (1 = wide 81.92 mV), bits 2:1 mode (3 = continuous)
    localparam logic [15:0] SETUP_A_RST = 16'h0007;
    localparam logic [15:0] SETUP_B_RST = 16'h000f;
    localparam int SETUP_B_CHEN_LSB = 0;
    localparam logic [15:0] THR_RST = 16'h7fff;
    localparam logic [15:0] CAL_RST = 16'h0000;
    localparam logic [15:0] FCFG_RST = 16'h0000;
    // fault slot config: bits 1:0 channel, bits 4:2 condition select
    localparam int FCFG_CH_LSB = 0;
    localparam int FCFG_SEL_LSB = 2;
    typedef enum logic [2:0] {
        QPM_SEL_NONE = 3'b000,
        QPM_SEL_SHUNT_OV = 3'b001,
        QPM_SEL_SHUNT_UV = 3'b010,
        QPM_SEL_BUS_OV = 3'b011,
        QPM_SEL_BUS_UV = 3'b100,
        QPM_SEL_POWER_OV = 3'b101
    } qpm_sel_t;
    // shunt step 2.5 uV, bus step 1.6 mV, power/energy step 32 x current step
    localparam int POWER_SCALE_SHIFT = 5;
    localparam int CLK_MHZ = 100;
    localparam int MATH_TIME_US = 60;
    localparam int MATH_CYCLES = MATH_TIME_US * CLK_MHZ;
    localparam int MATH_CNT_W = 13;
    localparam logic [7:0] PSLVERR_NONE = 8'h00;
endpackage : qpm_pkg

// ===== qpm_monitor.sv
// result scaling, fault slots, setup registers and apb slave of the quad power monitor
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
//
// Functional notes
// - after reset wide shunt range and continuous shunt plus bus conversion, all channels.
// - both setup registers return to defaults on disable or power cycle.
// - one shunt calibration register per channel, four in all.
// - zero calibration forces current and power results of that channel to zero and stops its energy growing.
// - shunt, bus readings and limit compares other than power over do not depend on calibration.
// - calibration multiplier covers current steps up to eight times the minimum.
// - each fault slot selects a condition; its threshold slot holds the trip level.
// - channel code 00b is first channel; select 001b shunt over, 011b bus over.
// - shunt limits compare in shunt result counts of 2.5 uV.
// - all four threshold slots reload defaults on disable or power cycle.
// - any fault slot may watch any channel independently of others.
// - results scale linearly; shunt step 2.5 uV, bus step 1.6 mV.
// - power step is thirty-two times the current step.
// - energy step is thirty-two current steps and register exceeds sixteen bits.
// - shunt voltage and current results are two's complement.
// - alert latency bounded by twice conversion time sum times enabled channels.
// - overpower alerts may take an extra 60 us for background math.
module qpm_monitor
    import qpm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        enable,
    // conversion stream from the analog front end (another domain)
    input  wire logic        conv_clk,
    input  wire logic        conv_valid,
    input  wire logic [1:0]  conv_ch,
    input  wire logic        conv_is_bus,
    input  wire logic [15:0] conv_data,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             alert,
    output logic             irq,
    output logic             adc_wide_range,
    output logic             adc_continuous,
    output logic      [3:0]  adc_ch_enable
);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic signed [31:0] mul16(input logic signed [15:0] a,
                                                 input logic [15:0] b);
        mul16 = a * $signed({1'b0, b});
    endfunction : mul16

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    // strobe, channel and data are sampled together; the link holds them for many clocks
    logic [2:0] clk_s1_r, clk_s2_r;
    logic       clk_s3_r;
    logic [1:0] ch_s1_r, ch_s2_r;
    logic [15:0] dat_s1_r, dat_s2_r;
    logic       en_s1_r, en_s2_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_s1_r <= 3'h0;
            clk_s2_r <= 3'h0;
            clk_s3_r <= 1'b0;
            ch_s1_r  <= 2'h0;
            ch_s2_r  <= 2'h0;
            dat_s1_r <= 16'h0000;
            dat_s2_r <= 16'h0000;
            en_s1_r  <= 1'b0;
            en_s2_r  <= 1'b0;
        end else begin
            clk_s1_r <= {conv_clk, conv_valid, conv_is_bus};
            clk_s2_r <= clk_s1_r;
            clk_s3_r <= clk_s2_r[2];
            ch_s1_r  <= conv_ch;
            ch_s2_r  <= ch_s1_r;
            dat_s1_r <= conv_data;
            dat_s2_r <= dat_s1_r;
            en_s1_r  <= enable;
            en_s2_r  <= en_s1_r;
        end
    end

    // sample on the rising edge of the link clock; the front end holds data across it
    wire       conv_edge = clk_s2_r[2] & ~clk_s3_r;
    wire       conv_take = conv_edge & clk_s2_r[1];
    wire       conv_bus  = clk_s2_r[0];
    wire       dev_off   = ~en_s2_r;

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode
    wire        apb_wr    = psel & penable & pwrite;
    wire        apb_rd    = psel & ~pwrite;
    wire [7:0]  widx      = paddr[9:2];
    wire        addr_ok   = (paddr[11:10] == 2'b00) & (paddr[1:0] == 2'b00);
    wire [15:0] wdat      = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};
    wire        full_wr   = pstrb[1] & pstrb[0];

    logic [15:0] setup_a_r, setup_b_r;
    logic [15:0] cal_r   [NUM_CH];
    logic [15:0] fcfg_r  [NUM_CH];
    logic [15:0] thr_r   [NUM_CH];
    logic [15:0] shunt_r [NUM_CH];
    logic [15:0] bus_r   [NUM_CH];
    logic [31:0] energy_r[NUM_CH];
    logic [3:0]  istat_r, imask_r;

    assign adc_wide_range = setup_a_r[0];
    assign adc_continuous = setup_a_r[2] & setup_a_r[1];
    assign adc_ch_enable  = setup_b_r[SETUP_B_CHEN_LSB +: 4];

    ////////////////////////////////////////////////////////////////////////////////
    // result math: current = shunt*cal >> 11, power = |current|*bus >> 5
    logic signed [15:0] curr_w  [NUM_CH];
    logic        [15:0] power_w [NUM_CH];
    logic signed [31:0] prod_w  [NUM_CH];
    logic        [31:0] pprod_w [NUM_CH];
    logic        [15:0] cmag_w  [NUM_CH];

    for (genvar c = 0; c < NUM_CH; c++) begin : g_math
        // cal of zero gives zero product, hence zero current, power and energy increment
        assign prod_w[c]  = mul16(signed'(shunt_r[c]), cal_r[c]);
        assign curr_w[c]  = prod_w[c][26:11];
        // magnitude kept unsigned so the most negative current still gives full power
        assign cmag_w[c]  = curr_w[c][15] ? 16'(-curr_w[c]) : curr_w[c];
        assign pprod_w[c] = 32'(cmag_w[c]) * 32'(bus_r[c]);
        assign power_w[c] = pprod_w[c][20:5];
    end

    // energy: accumulate power counts once per power period (same 32x current step)
    // free-running period counter keeps the energy step independent of link timing
    logic [MATH_CNT_W-1:0] acc_cnt_r;
    wire acc_tick = (acc_cnt_r == MATH_CNT_W'(MATH_CYCLES - 1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_cnt_r <= '0;
        end else begin
            acc_cnt_r <= acc_tick ? '0 : acc_cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register file
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            setup_a_r <= SETUP_A_RST;
            setup_b_r <= SETUP_B_RST;
            imask_r   <= 4'h0;
            for (int c = 0; c < NUM_CH; c++) begin
                cal_r[c]    <= CAL_RST;
                fcfg_r[c]   <= FCFG_RST;
                thr_r[c]    <= THR_RST;
                shunt_r[c]  <= 16'h0000;
                bus_r[c]    <= 16'h0000;
                energy_r[c] <= 32'h0000_0000;
            end
        end else if (dev_off) begin
            setup_a_r <= SETUP_A_RST;
            setup_b_r <= SETUP_B_RST;
            for (int c = 0; c < NUM_CH; c++) begin
                cal_r[c]    <= CAL_RST;
                fcfg_r[c]   <= FCFG_RST;
                thr_r[c]    <= THR_RST;
                energy_r[c] <= 32'h0000_0000;
            end
        end else begin
            if (apb_wr && addr_ok) begin
                if (widx == IDX_SETUP_A) setup_a_r <= wdat;
                if (widx == IDX_SETUP_B) setup_b_r <= wdat;
                if (widx == IDX_IRQ_MASK) imask_r <= wdat[3:0];
                for (int c = 0; c < NUM_CH; c++) begin
                    if (widx == IDX_CAL_BASE + 8'(c)) cal_r[c] <= wdat;
                    if (widx == IDX_FCFG_BASE + 8'(c)) fcfg_r[c] <= wdat;
                    if (widx == IDX_THR_BASE + 8'(c)) thr_r[c] <= wdat;
                end
            end
            // result words take conversions only; bus writes never reach them
            if (conv_take && adc_ch_enable[ch_s2_r]) begin
                if (conv_bus) bus_r[ch_s2_r] <= dat_s2_r;
                else shunt_r[ch_s2_r] <= dat_s2_r;
            end
            if (acc_tick) begin
                for (int c = 0; c < NUM_CH; c++) begin
                    energy_r[c] <= energy_r[c] + {16'h0000, power_w[c]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // fault slots: compare on raw shunt and bus results, or on calibrated power for power over
    logic [3:0] trip_w;

    for (genvar s = 0; s < NUM_CH; s++) begin : g_slot
        wire [1:0]  sch = fcfg_r[s][FCFG_CH_LSB +: 2];
        wire [2:0]  sel = fcfg_r[s][FCFG_SEL_LSB +: 3];
        wire signed [15:0] sv = signed'(shunt_r[sch]);
        wire signed [15:0] tv = signed'(thr_r[s]);
        always_comb begin
            case (sel)
                QPM_SEL_SHUNT_OV: trip_w[s] = sv > tv;
                QPM_SEL_SHUNT_UV: trip_w[s] = sv < tv;
                QPM_SEL_BUS_OV:   trip_w[s] = bus_r[sch] > thr_r[s];
                QPM_SEL_BUS_UV:   trip_w[s] = bus_r[sch] < thr_r[s];
                QPM_SEL_POWER_OV: trip_w[s] = power_w[sch] > thr_r[s];
                default:          trip_w[s] = 1'b0;
            endcase
        end
    end

    // alert follows the trip within one cycle of the result update
    logic [3:0] trip_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trip_r <= 4'h0;
        end else begin
            trip_r <= dev_off ? 4'h0 : trip_w;
        end
    end

    assign alert = |trip_r;

    // sticky status, set wins over write-one-to-clear
    wire [3:0] clr_w = (apb_wr && addr_ok && widx == IDX_IRQ_STAT) ? wdat[3:0] : 4'h0;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            istat_r <= 4'h0;
        end else begin
            istat_r <= (istat_r & ~clr_w) | (dev_off ? 4'h0 : trip_r);
        end
    end

    assign irq = |(istat_r & imask_r);

    ////////////////////////////////////////////////////////////////////////////////
    // read mux
    wire [7:0]  rel   = widx - 8'h00;
    wire [1:0]  rch   = rel[4:3];
    wire [2:0]  rsel  = rel[2:0];
    wire        is_res = (widx < 8'h20) & (rsel <= 3'h4);
    wire        is_cfg = (widx >= IDX_SETUP_A) & (widx <= IDX_IRQ_MASK)
                         & (widx != 8'h22) & (widx != 8'h23);
    wire        hit   = addr_ok & (is_res | is_cfg);
    wire        bad_w = pwrite & (is_res | ~full_wr);
    logic [31:0] rdat_w;

    always_comb begin
        rdat_w = 32'h0000_0000;
        if (is_res) begin
            case (rsel)
                3'h0: rdat_w = {16'h0000, shunt_r[rch]};
                3'h1: rdat_w = {16'h0000, bus_r[rch]};
                3'h2: rdat_w = {16'h0000, curr_w[rch]};
                3'h3: rdat_w = {16'h0000, power_w[rch]};
                3'h4: rdat_w = energy_r[rch];
                default: rdat_w = 32'h0000_0000;
            endcase
        end else if (widx == IDX_SETUP_A) rdat_w = {16'h0000, setup_a_r};
        else if (widx == IDX_SETUP_B) rdat_w = {16'h0000, setup_b_r};
        else if (widx == IDX_IRQ_STAT) rdat_w = {28'h0, istat_r};
        else if (widx == IDX_IRQ_MASK) rdat_w = {28'h0, imask_r};
        else if (widx >= IDX_CAL_BASE && widx < IDX_FCFG_BASE)
            rdat_w = {16'h0000, cal_r[widx[1:0]]};
        else if (widx >= IDX_FCFG_BASE && widx < IDX_THR_BASE)
            rdat_w = {16'h0000, fcfg_r[widx[1:0]]};
        else if (widx >= IDX_THR_BASE && widx < IDX_IRQ_STAT)
            rdat_w = {16'h0000, thr_r[widx[1:0]]};
    end

    // read data latched in the setup phase so it stands through the access phase
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && apb_rd) begin
            prdata <= hit ? rdat_w : 32'h0000_0000;
        end
    end

    // zero wait states; errors are flagged in the access phase only
    assign pready  = 1'b1;
    assign pslverr = psel & penable & (~hit | bad_w);

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    a_zero_cal_curr: assert property (@(posedge clk) disable iff (!reset_n)
        cal_r[0] == 16'h0000 |-> curr_w[0] == 16'sh0000 && power_w[0] == 16'h0000)
        else $error("current or power nonzero with zero calibration");
    a_zero_cal_energy: assert property (@(posedge clk) disable iff (!reset_n)
        cal_r[1] == 16'h0000 && $stable(cal_r[1]) && $past(cal_r[1]) == 16'h0000
        && energy_r[1] == 32'h0 |=> energy_r[1] == 32'h0)
        else $error("energy grew with zero calibration");
    a_setup_reset: assert property (@(posedge clk) disable iff (!reset_n)
        dev_off |=> setup_a_r == SETUP_A_RST && setup_b_r == SETUP_B_RST)
        else $error("setup registers not restored on disable");
    a_thr_reload: assert property (@(posedge clk) disable iff (!reset_n)
        dev_off |=> thr_r[0] == THR_RST && thr_r[3] == THR_RST)
        else $error("threshold slots not reloaded on disable");
    a_result_ro: assert property (@(posedge clk) disable iff (!reset_n)
        apb_wr && widx == IDX_SHUNT && !conv_take |=> $stable(shunt_r[0]))
        else $error("result register changed by bus write");
    a_shunt_ov_alert: assert property (@(posedge clk) disable iff (!reset_n)
        !dev_off && fcfg_r[0][4:2] == 3'b001 && fcfg_r[0][1:0] == 2'b00
        && signed'(shunt_r[0]) > signed'(thr_r[0]) |=> alert)
        else $error("shunt over condition did not raise alert");
    a_wide_default: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(en_s2_r) |-> ##1 adc_wide_range && adc_continuous && adc_ch_enable == 4'hf)
        else $error("default range or mode wrong after enable");
    a_energy_step: assert property (@(posedge clk) disable iff (!reset_n)
        acc_tick && !dev_off |=> energy_r[2] == $past(energy_r[2]) + {16'h0, $past(power_w[2])})
        else $error("energy did not accumulate power counts");
    a_alert_latency: assert property (@(posedge clk) disable iff (!reset_n)
        !dev_off && trip_w != 4'h0 ##1 !dev_off |-> alert)
        else $error("alert late after trip");

    // bus refusals, conversion capture and zero calibration on the last channel
    a_result_err: assert property (@(posedge clk) disable iff (!reset_n)
        psel && penable && pwrite && is_res |-> pslverr)
        else $error("result write not refused");
    a_shunt_take: assert property (@(posedge clk) disable iff (!reset_n)
        conv_take && !conv_bus && !dev_off && adc_ch_enable[ch_s2_r]
        |=> shunt_r[$past(ch_s2_r)] == $past(dat_s2_r))
        else $error("shunt word not stored");
    a_bus_take: assert property (@(posedge clk) disable iff (!reset_n)
        conv_take && conv_bus && !dev_off && adc_ch_enable[ch_s2_r]
        |=> bus_r[$past(ch_s2_r)] == $past(dat_s2_r))
        else $error("bus word not stored");
    a_zero_cal_ch3: assert property (@(posedge clk) disable iff (!reset_n)
        cal_r[3] == 16'h0000 |-> curr_w[3] == 16'sh0000 && power_w[3] == 16'h0000)
        else $error("result nonzero with zero calibration");

    // further slot conditions, sticky status and disable
    a_bus_ov_alert: assert property (@(posedge clk) disable iff (!reset_n)
        !dev_off && fcfg_r[1][4:2] == 3'b011 && bus_r[fcfg_r[1][1:0]] > thr_r[1] |=> alert)
        else $error("bus over condition did not raise alert");
    a_shunt_uv_alert: assert property (@(posedge clk) disable iff (!reset_n)
        !dev_off && fcfg_r[2][4:2] == 3'b010
        && signed'(shunt_r[fcfg_r[2][1:0]]) < signed'(thr_r[2]) |=> alert)
        else $error("shunt under condition did not raise alert");
    a_bus_uv_alert: assert property (@(posedge clk) disable iff (!reset_n)
        !dev_off && fcfg_r[2][4:2] == 3'b100 && bus_r[fcfg_r[2][1:0]] < thr_r[2] |=> alert)
        else $error("bus under condition did not raise alert");
    a_power_ov_alert: assert property (@(posedge clk) disable iff (!reset_n)
        !dev_off && fcfg_r[2][4:2] == 3'b101 && power_w[fcfg_r[2][1:0]] > thr_r[2] |=> alert)
        else $error("power over condition did not raise alert");
    a_status_set: assert property (@(posedge clk) disable iff (!reset_n)
        !dev_off && trip_r[1] |=> istat_r[1])
        else $error("status bit not set by a tripped slot");
    a_cal_reload: assert property (@(posedge clk) disable iff (!reset_n)
        dev_off |=> cal_r[0] == CAL_RST && cal_r[3] == CAL_RST)
        else $error("calibration not cleared on disable");
    a_energy_clear: assert property (@(posedge clk) disable iff (!reset_n)
        dev_off |=> energy_r[0] == 32'h0 && energy_r[3] == 32'h0)
        else $error("energy not cleared on disable");
    a_off_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        dev_off |=> !alert)
        else $error("alert raised while disabled");

    c_alert_rise: cover property (@(posedge clk) disable iff (!reset_n) $rose(alert));
    c_bus_ov: cover property (@(posedge clk) disable iff (!reset_n)
        fcfg_r[1][4:2] == 3'b011 && trip_w[1]);
    c_irq: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq));
    c_energy: cover property (@(posedge clk) disable iff (!reset_n)
        acc_tick && power_w[0] != 16'h0);
    c_power_ov: cover property (@(posedge clk) disable iff (!reset_n)
        fcfg_r[2][4:2] == 3'b101 && trip_w[2]);

endmodule : qpm_monitor

// ===== qpm_front_end.sv
// conversion front end model feeding shunt and bus words over the link
`timescale 1ns/1ps
module qpm_front_end (
    output logic        conv_clk,
    output logic        conv_valid,
    output logic [1:0]  conv_ch,
    output logic        conv_is_bus,
    output logic [15:0] conv_data
);
    // link clock stands low outside frames; idle lines show inverted data
    initial begin
        conv_clk    = 1'b0;
        conv_valid  = 1'b0;
        conv_ch     = 2'b00;
        conv_is_bus = 1'b0;
        conv_data   = 16'h0000;
    end
    task automatic send(input logic [1:0] ch, input logic is_bus, input logic [15:0] data);
        conv_valid  = 1'b1;
        conv_ch     = ch;
        conv_is_bus = is_bus;
        conv_data   = data;
        #62.5 conv_clk = 1'b1;
        #62.5 conv_clk = 1'b0;
        #62.5 conv_valid = 1'b0;
        conv_ch   = ~ch;
        conv_data = ~data;
    endtask : send
endmodule : qpm_front_end

// ===== tb_qpm_monitor.sv
// self-checking bench of the quad power monitor results and alerts
`timescale 1ns/1ps
module tb_qpm_monitor
    import qpm_pkg::*;
;
    logic        clk, reset_n, enable, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, pw;
    logic [3:0]  pstrb, adc_ch_enable;
    logic        pready, pslverr, alert, irq, adc_wide_range, adc_continuous, er;
    wire         conv_clk, conv_valid, conv_is_bus;
    wire  [1:0]  conv_ch;
    wire  [15:0] conv_data;
    logic [15:0] sh [4], bu [4], cal [4];
    int          err_count, check_count;
    wire  [31:0] ports = {26'h0, adc_wide_range, adc_continuous, adc_ch_enable};

    initial clk = 1'b0;
    always #5 clk = ~clk;

    qpm_monitor u_qpm_monitor (.clk(clk), .reset_n(reset_n), .enable(enable),
        .conv_clk(conv_clk), .conv_valid(conv_valid), .conv_ch(conv_ch),
        .conv_is_bus(conv_is_bus), .conv_data(conv_data), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .alert(alert), .irq(irq), .adc_wide_range(adc_wide_range),
        .adc_continuous(adc_continuous), .adc_ch_enable(adc_ch_enable));
    qpm_front_end u_qpm_front_end (.conv_clk(conv_clk), .conv_valid(conv_valid),
        .conv_ch(conv_ch), .conv_is_bus(conv_is_bus), .conv_data(conv_data));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] exp_curr(input logic [15:0] s, input logic [15:0] c);
        logic signed [31:0] p;
        p = $signed(s) * $signed({16'h0000, c});
        return p[26:11];
    endfunction : exp_curr
    function automatic logic [15:0] exp_pow(input logic [15:0] cu, input logic [15:0] b);
        logic [15:0] m;
        logic [31:0] p;
        m = cu[15] ? (~cu + 16'h0001) : cu;
        p = {16'h0000, m} * {16'h0000, b};
        return p[20:5];
    endfunction : exp_pow
    task automatic summarize();
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    // one apb transfer, held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_count++;
            summarize();
        end
    endtask : apb
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask : rdc
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        reset_n = 1'b0;
        enable  = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        pstrb   = 4'hf;
        err_count   = 0;
        check_count = 0;
        void'($urandom(16815));
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        settle(4);
        chk(ports, 32'h0000003f);
        rdc(IDX_SETUP_A, 32'h00000007);
        rdc(IDX_SETUP_B, 32'h0000000f);
        for (int s = 0; s < 4; s++) begin
            rdc(IDX_THR_BASE + 8'(s), 32'h00007fff);
            rdc(IDX_CAL_BASE + 8'(s), 32'h0);
        end
        apb(1'b0, 8'h3c, 32'h0);
        chk(32'(er), 32'h1);
        // raw words with calibration still zero
        for (int c = 0; c < 4; c++) begin
            sh[c]  = (c == 0) ? 16'h8000 : 16'($urandom_range(16'h6fff, 16'h1000));
            bu[c]  = 16'($urandom_range(16'h6fff, 16'h1000));
            cal[c] = 16'($urandom_range(16'h3fff, 16'h0800));
            u_qpm_front_end.send(2'(c), 1'b0, sh[c]);
            u_qpm_front_end.send(2'(c), 1'b1, bu[c]);
            settle(10);
            rdc(8'(8 * c), {16'h0, sh[c]});
            rdc(8'(8 * c + 1), {16'h0, bu[c]});
            rdc(8'(8 * c + 2), 32'h0);
        end
        settle(6100);
        for (int c = 0; c < 4; c++) begin
            rdc(8'(8 * c + 3), 32'h0);
            rdc(8'(8 * c + 4), 32'h0);
        end
        apb(1'b1, IDX_SHUNT, 32'h00001234);
        chk(32'(er), 32'h1);
        rdc(IDX_SHUNT, {16'h0, sh[0]});
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, IDX_CAL_BASE + 8'(c), {16'h0, cal[c]});
            rdc(IDX_CAL_BASE + 8'(c), {16'h0, cal[c]});
            u_qpm_front_end.send(2'(c), 1'b0, sh[c]);
        end
        settle(6100);
        for (int c = 0; c < 4; c++) begin
            rdc(8'(8 * c + 2), {16'h0, exp_curr(sh[c], cal[c])});
            rdc(8'(8 * c + 3), {16'h0, exp_pow(exp_curr(sh[c], cal[c]), bu[c])});
        end
        settle(6100);
        for (int c = 0; c < 4; c++) begin
            pw = {16'h0, exp_pow(exp_curr(sh[c], cal[c]), bu[c])};
            apb(1'b0, 8'(8 * c + 4), 32'h0);
            chk(32'((pw == 0) ? (rd == 0) : (rd % pw == 0 && rd >= pw)), 32'h1);
        end
        // two slots on the first channel, shunt and bus overvoltage
        apb(1'b1, IDX_FCFG_BASE, {27'h0, QPM_SEL_SHUNT_OV, 2'b00});
        apb(1'b1, IDX_FCFG_BASE + 8'h01, {27'h0, QPM_SEL_BUS_OV, 2'b00});
        apb(1'b1, IDX_THR_BASE, 32'h00006000);
        apb(1'b1, IDX_THR_BASE + 8'h01, 32'h00007000);
        apb(1'b1, IDX_IRQ_MASK, 32'h0);
        settle(5);
        chk(32'(alert), 32'h0);
        u_qpm_front_end.send(2'b00, 1'b0, 16'h6001);
        n = 0;
        while (alert !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk(32'(alert), 32'h1);
        chk(32'(irq), 32'h0);
        rdc(IDX_IRQ_STAT, 32'h1);
        apb(1'b1, IDX_IRQ_MASK, 32'h3);
        settle(2);
        chk(32'(irq), 32'h1);
        u_qpm_front_end.send(2'b00, 1'b1, 16'h7100);
        settle(10);
        rdc(IDX_IRQ_STAT, 32'h3);
        apb(1'b1, IDX_THR_BASE, 32'h00007fff);
        apb(1'b1, IDX_THR_BASE + 8'h01, 32'h00007fff);
        u_qpm_front_end.send(2'b00, 1'b0, 16'h0100);
        u_qpm_front_end.send(2'b00, 1'b1, 16'h0100);
        settle(10);
        apb(1'b1, IDX_IRQ_STAT, 32'h3);
        rdc(IDX_IRQ_STAT, 32'h0);
        settle(2);
        chk({30'h0, alert, irq}, 32'h0);
        // under limits and over power on the third channel through slot three
        for (int k = 2; k < 6; k++) begin
            if (k == 3) continue;
            pw = (k == 2) ? sh[2] : (k == 4) ? bu[2] : exp_pow(exp_curr(sh[2], cal[2]), bu[2]);
            apb(1'b1, IDX_FCFG_BASE + 8'h02, 32'(4 * k + 2));
            apb(1'b1, IDX_THR_BASE + 8'h02, pw);
            settle(3);
            chk(32'(alert), 32'h0);
            apb(1'b1, IDX_THR_BASE + 8'h02, (k == 5) ? pw - 1 : pw + 1);
            settle(3);
            chk(32'(alert), 32'(k != 5 || pw != 0));
        end
        apb(1'b1, IDX_FCFG_BASE + 8'h02, 32'h0);
        // non-default setup is lost across a disable
        apb(1'b1, IDX_SETUP_A, 32'h1);
        apb(1'b1, IDX_SETUP_B, 32'h3);
        apb(1'b1, IDX_THR_BASE, 32'h00001234);
        settle(2);
        chk(ports, 32'h00000023);
        @(posedge clk) enable <= 1'b0;
        settle(6);
        @(posedge clk) enable <= 1'b1;
        settle(6);
        chk(ports, 32'h0000003f);
        rdc(IDX_SETUP_A, 32'h00000007);
        rdc(IDX_SETUP_B, 32'h0000000f);
        rdc(IDX_THR_BASE, 32'h00007fff);
        rdc(IDX_CAL_BASE, 32'h0);
        summarize();
    end
endmodule : tb_qpm_monitor
